// [crc8_bank.sv]
`timescale 1ns/100ps
`include "sync_crc_map.svh"

module crc8_bank #(
  parameter int CH = `NUM_CHANNELS
) (
  // clock and reset
  input  wire logic    clk,
  input  wire logic    rst_n,
  // framer side
  sync_crc_if.bank     bif
);
  import sync_crc_pkg::*;

  // ----------------------------------------------------------------------------
  // bitwise fold of one sample, msb first
  // ----------------------------------------------------------------------------
  function automatic crc_type crc_fold(input crc_type acc, input sample_type dat);
    crc_type c;
    logic    fb;
    c = acc;
    for (int i = `DATA_BITS - 1; i >= 0; i--) begin
      fb = dat[i] ^ c[7];                                // see RL13
      c  = {c[6:2], c[1] ^ fb, c[0] ^ fb, fb};           // see RL12
    end
    return c;
  endfunction : crc_fold

  // ----------------------------------------------------------------------------
  // per-channel accumulators
  // ----------------------------------------------------------------------------
  for (genvar g = 0; g < CH; g++) begin : g_ch
    crc_type acc_q, acc_d, fold;

    always_comb begin
      fold = crc_fold(acc_q, bif.crc_data[g*16 +: 16]);
      acc_d = acc_q;
      if (bif.crc_preset) begin
        acc_d = `CRC_PRESET;                             // see RL8 RL10
      end else if (bif.crc_update) begin
        acc_d = fold;
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        acc_q <= `CRC_PRESET;
      end else begin
        acc_q <= acc_d;
      end
    end

    assign bif.crc_now[g*8 +: 8] = fold;
  end

endmodule : crc8_bank

// [sync_crc_framer.sv]
`timescale 1ns/100ps
`include "sync_crc_map.svh"
// Function
// RL1 - async start pin yields clock-aligned sync output
// RL2 - serial-port sync command also pulses sync output
// RL3 - system loops first sync output to inputs
// RL4 - unused start pins are tied high
// RL5 - synchronous sync input sampled on rising clock
// RL6 - channel word: 8-bit header plus 16 data
// RL7 - crc select replaces header every 4/16
// RL8 - sync presets every crc accumulator to ones
// RL9 - fourth header carries crc over four samples
// RL10 - after crc header, preset and repeat
// RL11 - crc header on all channels together
// RL12 - polynomial x^8 + x^2 + x + 1
// RL13 - msb first, bit xor crc7 into 0..2
module sync_crc_framer #(
  parameter int CH = `NUM_CHANNELS
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // synchronisation pins
  input  wire logic                       start_n,
  output logic                            sync_out_n,
  input  wire logic                       sync_in_n,
  // configuration
  input  wire logic                       spi_mode,
  input  wire logic                       spi_sync_cmd,
  input  wire sync_crc_pkg::crc_sel_type  crc_select,
  // converter results
  input  wire logic                       sample_valid,
  output logic                            sample_ready,
  input  wire logic [CH*16-1:0]           sample_data,
  input  wire logic [CH*8-1:0]            status_hdr,
  // serial link
  input  wire logic                       dclk,
  output logic                            data_ready_strobe_n,
  output logic [CH-1:0]                   dout
);
  import sync_crc_pkg::*;

  // ----------------------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------------------
  // the crc bank and the word registers are laid out for at most 16 channels
  if (CH < 1 || CH > 16) begin : g_bad_ch
    $error("channel count out of range");
  end
  if (`WORD_BITS != `HDR_BITS + `DATA_BITS) begin : g_bad_word
    $error("word layout does not add up");
  end

  // ----------------------------------------------------------------------------
  // local constants
  // ----------------------------------------------------------------------------
  // the rise after bit 0 ends the word
  localparam logic [4:0] PARK_RISE = `WORD_MSB + 5'h1;

  // ----------------------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------------------
  // the pulse generator only requests; the sync event comes back on sync_in_n
  sync_crc_if #(.CH(CH)) sif ();

  sync_pulse_gen u_sync (
    .clk          (clk),
    .rst_n        (rst_n),
    .start_n      (start_n),
    .spi_mode     (spi_mode),
    .spi_sync_cmd (spi_sync_cmd),
    .sif          (sif.gen)
  );

  crc8_bank #(
    .CH (CH)
  ) u_crc (
    .clk   (clk),
    .rst_n (rst_n),
    .bif   (sif.bank)
  );

  // ----------------------------------------------------------------------------
  // sync output and sync input
  // ----------------------------------------------------------------------------
  // sync_out_n is meant to be looped back to sync_in_n by the board
  logic sync_out_q;
  logic sync_out_d;
  logic sin_q;
  logic sin_d;
  logic sin_h_q;
  logic sin_h_d;
  logic sync_evt;

  always_comb begin
    sync_out_d = ~sif.sync_req;                          // see RL1 RL2 RL3
    sin_d      = sync_in_n;                              // see RL5
    sin_h_d    = sin_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_out_q <= 1'b1;
      sin_q      <= 1'b1;
      sin_h_q    <= 1'b1;
    end else begin
      sync_out_q <= sync_out_d;
      sin_q      <= sin_d;
      sin_h_q    <= sin_h_d;
    end
  end

  assign sync_out_n = sync_out_q;
  // sync_in is already clock-aligned, so one sampling stage suffices
  assign sync_evt   = sin_h_q & ~sin_q;                  // see RL5 RL8

  // ----------------------------------------------------------------------------
  // frame counting and header selection
  // ----------------------------------------------------------------------------
  // position of the next frame inside its crc group, counted from the last sync
  logic [3:0] frm_q;
  logic [3:0] frm_d;
  logic       crc_en;
  logic       close;
  logic       take;
  logic [3:0] last_idx;

  assign crc_en = spi_mode && (crc_select != `CRC_SEL_OFF);     // see RL7
  assign take   = sample_valid & sample_ready;
  // one counter for all channels keeps crc headers aligned
  assign close  = (frm_q == last_idx);                          // see RL11

  // selections 2 and 3 both give groups of sixteen
  always_comb begin
    last_idx = `GROUP_SIXT_LAST;
    if (crc_select == `CRC_SEL_FOUR) begin
      last_idx = `GROUP_FOUR_LAST;
    end
  end

  always_comb begin
    frm_d = frm_q;
    if (sync_evt) begin
      frm_d = 4'h0;
    end else if (take) begin
      if (close) begin
        frm_d = 4'h0;                                           // see RL10
      end else begin
        frm_d = frm_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frm_q <= 4'h0;
    end else begin
      frm_q <= frm_d;
    end
  end

  // sync wins over a frame taken in the same cycle
  assign sif.crc_preset = sync_evt | (take & close);            // see RL8 RL10
  assign sif.crc_update = take;                                 // see RL9
  assign sif.crc_data   = sample_data;

  // ----------------------------------------------------------------------------
  // dclk edge detection
  // ----------------------------------------------------------------------------
  // dclk is sampled, so its rising edge is seen two to three clocks late; the
  // link clock must stay several clock periods in each phase
  logic dck_m_q;
  logic dck_s_q;
  logic dck_h_q;
  logic dck_m_d;
  logic dck_s_d;
  logic dck_h_d;
  logic dck_rise;

  always_comb begin
    dck_m_d = dclk;
    dck_s_d = dck_m_q;
    dck_h_d = dck_s_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dck_m_q <= 1'b0;
      dck_s_q <= 1'b0;
      dck_h_q <= 1'b0;
    end else begin
      dck_m_q <= dck_m_d;
      dck_s_q <= dck_s_d;
      dck_h_q <= dck_h_d;
    end
  end

  assign dck_rise = dck_s_q & ~dck_h_q;

  // ----------------------------------------------------------------------------
  // word assembly and serialiser
  // ----------------------------------------------------------------------------
  // a frame offered while a word is still shifting is held off by sample_ready
  ser_state_type         st_q;
  ser_state_type         st_d;
  logic [4:0]            bit_q;
  logic [4:0]            bit_d;
  logic                  data_ready_strobe_q;
  logic                  data_ready_strobe_d;

  assign sample_ready = (st_q == SER_IDLE);

  always_comb begin
    st_d   = st_q;
    bit_d  = bit_q;
    data_ready_strobe_d = data_ready_strobe_q;
    case (st_q)
      SER_IDLE: begin
        if (take) begin
          st_d = SER_ARMED;
        end
      end
      SER_ARMED: begin
        if (dck_rise) begin
          data_ready_strobe_d = 1'b0;
          bit_d  = 5'h1;
          st_d   = SER_SHIFT;
        end
      end
      SER_SHIFT: begin
        if (dck_rise) begin
          data_ready_strobe_d = 1'b1;
          if (bit_q == PARK_RISE) begin
            st_d = SER_IDLE;
          end else begin
            bit_d = bit_q + 5'h1;
          end
        end
      end
      default: begin
        st_d = SER_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= SER_IDLE;
      bit_q  <= 5'h0;
      data_ready_strobe_q <= 1'b1;
    end else begin
      st_q   <= st_d;
      bit_q  <= bit_d;
      data_ready_strobe_q <= data_ready_strobe_d;
    end
  end

  assign data_ready_strobe_n = data_ready_strobe_q;

  // each channel keeps its own word and line; state and strobe are shared, so
  // every channel shifts the same bit in the same cycle
  for (genvar g = 0; g < CH; g++) begin : g_word
    logic [7:0]            hdr;
    logic [`WORD_BITS-1:0] word_q;
    logic [`WORD_BITS-1:0] word_d;
    logic                  line_q;
    logic                  line_d;

    // crc replaces the status header on the closing frame
    always_comb begin
      hdr = status_hdr[g*8 +: 8];
      if (crc_en && close) begin
        hdr = sif.crc_now[g*8 +: 8];                           // see RL7 RL9 RL11
      end
    end

    always_comb begin
      word_d = word_q;
      line_d = line_q;
      if (take) begin
        word_d = {hdr, sample_data[g*16 +: 16]};               // see RL6
      end else if (dck_rise && st_q != SER_IDLE) begin
        if (st_q == SER_SHIFT && bit_q == PARK_RISE) begin
          // the rise after the last bit parks the line low for the idle period
          line_d = 1'b0;
        end else begin
          line_d = word_q[`WORD_BITS-1];
          word_d = {word_q[`WORD_BITS-2:0], 1'b0};
        end
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        word_q <= '0;
        line_q <= 1'b0;
      end else begin
        word_q <= word_d;
        line_q <= line_d;
      end
    end

    assign dout[g] = line_q;
  end

endmodule : sync_crc_framer

// [sync_crc_framer_assertions.sv]
`timescale 1ns/100ps

module sync_crc_framer_assertions #(
  parameter int CH = 8
) (
  // clock and reset
  input wire logic          clk,
  input wire logic          rst_n,
  // sync
  input wire logic          start_n,
  input wire logic          sync_out_n,
  input wire logic          spi_mode,
  input wire logic          spi_sync_cmd,
  // frames
  input wire logic          sample_valid,
  input wire logic          sample_ready,
  input wire logic          data_ready_strobe_n,
  input wire logic [CH-1:0] dout
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ------
  // sequences
  // ------
  sequence spi_req_s;
    spi_mode && spi_sync_cmd;
  endsequence
  sequence take_s;
    sample_valid && sample_ready;
  endsequence
  // ------
  // checks
  // ------
  chk_spi_sync: assert property (spi_req_s |-> ##2 !sync_out_n)
    else $error("no pulse after sync command");
  chk_sync_cause: assert property ($fell(sync_out_n) |->
    ($past(spi_mode, 2) && $past(spi_sync_cmd, 2)) || !$past(start_n, 2))
    else $error("sync pulse without a cause");
  chk_start_sync: assert property ($fell(start_n) |-> ##[2:8] $fell(sync_out_n))
    else $error("no pulse after start");
  chk_sync_single: assert property ($fell(sync_out_n) && !$past(spi_sync_cmd) |=> sync_out_n)
    else $error("sync pulse too long");
  chk_take_busy: assert property (take_s |=> !sample_ready)
    else $error("frame not taken");
  chk_idle_lines: assert property (sample_ready |-> data_ready_strobe_n && dout == '0)
    else $error("link not idle");
  chk_strobe_taken: assert property ($fell(data_ready_strobe_n) |-> !sample_ready)
    else $error("strobe without frame");
  chk_first_bit: assert property ($fell(data_ready_strobe_n) |=>
    (!data_ready_strobe_n && $stable(dout)) [*8])
    else $error("first bit not held");
endmodule : sync_crc_framer_assertions

// [sync_crc_if.sv]
`timescale 1ns/100ps

interface sync_crc_if #(
  parameter int CH = 8
);
  logic                sync_req;
  logic                crc_preset;
  logic                crc_update;
  logic [CH*16-1:0]    crc_data;
  logic [CH*8-1:0]     crc_now;

  modport gen  (output sync_req);
  modport bank (input  crc_preset, input crc_update, input crc_data, output crc_now);
  modport ctrl (input  sync_req, output crc_preset, output crc_update, output crc_data,
                input  crc_now);
endinterface : sync_crc_if

// [sync_crc_map.svh]
`ifndef SYNC_CRC_MAP_SVH
`define SYNC_CRC_MAP_SVH

// ----------------------------------------------------------------------------
// word layout
// ----------------------------------------------------------------------------
`define HDR_BITS        8
`define DATA_BITS       16
`define WORD_BITS       24
`define WORD_MSB        5'h17

// ----------------------------------------------------------------------------
// crc constants
// ----------------------------------------------------------------------------
`define CRC_PRESET      8'hFF
`define CRC_SEL_OFF     2'h0
`define CRC_SEL_FOUR    2'h1
`define GROUP_FOUR_LAST 4'h3
`define GROUP_SIXT_LAST 4'hF

// ----------------------------------------------------------------------------
// default sizes
// ----------------------------------------------------------------------------
`define NUM_CHANNELS    8

`endif

// [sync_crc_pkg.sv]
package sync_crc_pkg;

  // ----------------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SER_IDLE,
    SER_ARMED,
    SER_SHIFT
  } ser_state_type;

  typedef logic [1:0] crc_sel_type;
  typedef logic [7:0] crc_type;
  typedef logic [15:0] sample_type;

endpackage : sync_crc_pkg

// [sync_frame_host.sv]
`timescale 1ns/100ps

module sync_frame_host #(
  parameter int CH   = 2,
  parameter int HALF = 80
) (
  // clock
  input  wire logic              clk,
  // link
  input  wire logic              sample_ready,
  input  wire logic              data_ready_strobe_n,
  input  wire logic [CH-1:0]     dout,
  output logic                   dclk,
  // captured words
  output logic [CH*24-1:0]       words,
  output int                     got
);
  logic [CH*24-1:0] sh;
  int               cnt;

  // link clock stands low between frames
  initial begin
    dclk = 1'b0;
    forever begin
      @(posedge clk iff !sample_ready);
      #3;
      while (!sample_ready) begin
        #HALF dclk = 1'b1;
        #HALF dclk = 1'b0;
      end
    end
  end

  // bits taken mid-period; strobe marks bit 23
  initial begin
    got = 0;
    cnt = 24;
    sh = '0;
    words = '0;
    forever begin
      @(negedge dclk);
      if (!data_ready_strobe_n) cnt = 0;
      if (cnt < 24) begin
        for (int g = 0; g < CH; g++) sh[g*24 +: 24] = {sh[g*24 +: 23], dout[g]};
        cnt++;
        if (cnt == 24) begin
          words = sh;
          got++;
        end
      end
    end
  end
endmodule : sync_frame_host

// [sync_pulse_gen.sv]
`timescale 1ns/100ps
`include "sync_crc_map.svh"

module sync_pulse_gen (
  // clock and reset
  input  wire logic    clk,
  input  wire logic    rst_n,
  // sources
  input  wire logic    start_n,
  input  wire logic    spi_mode,
  input  wire logic    spi_sync_cmd,
  // to framer
  sync_crc_if.gen      sif
);
  import sync_crc_pkg::*;

  // ----------------------------------------------------------------------------
  // start pin retiming
  // ----------------------------------------------------------------------------
  // start is asynchronous; the first stage feeds only the second
  logic start_m_q, start_s_q, start_h_q;
  logic start_m_d, start_s_d, start_h_d;
  logic req_q, req_d;

  always_comb begin
    start_m_d = start_n;
    start_s_d = start_m_q;
    start_h_d = start_s_q;
    // falling edge of the retimed start, or a serial-port sync command
    req_d     = (start_h_q & ~start_s_q)               // see RL1
              | (spi_mode & spi_sync_cmd);             // see RL2
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_m_q <= 1'b1;
      start_s_q <= 1'b1;
      start_h_q <= 1'b1;
      req_q     <= 1'b0;
    end else begin
      start_m_q <= start_m_d;
      start_s_q <= start_s_d;
      start_h_q <= start_h_d;
      req_q     <= req_d;
    end
  end

  assign sif.sync_req = req_q;

endmodule : sync_pulse_gen

// [test_sync_and_crc_header_framer.sv]
`timescale 1ns/100ps

module test_sync_and_crc_header_framer;
  import sync_crc_pkg::*;
  localparam int CH = 2;
  logic             clk, rst_n, start_n, sync_out_n, sync_in_n, ext_sync_n;
  logic             spi_mode, spi_sync_cmd, sample_valid, sample_ready;
  logic             dclk, data_ready_strobe_n;
  crc_sel_type      crc_select;
  logic [CH*16-1:0] sample_data;
  logic [CH*8-1:0]  status_hdr;
  logic [CH-1:0]    dout;
  logic [CH*24-1:0] words;
  logic [7:0]       acc [CH];
  int               got, fails, check_count, cycles, fc;

  // first converter's sync output loops to its own input
  assign sync_in_n = sync_out_n & ext_sync_n;

  sync_crc_framer #(.CH(CH)) sync_crc_framer_inst (
    .clk(clk), .rst_n(rst_n), .start_n(start_n), .sync_out_n(sync_out_n),
    .sync_in_n(sync_in_n), .spi_mode(spi_mode), .spi_sync_cmd(spi_sync_cmd),
    .crc_select(crc_select), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_data(sample_data), .status_hdr(status_hdr), .dclk(dclk),
    .data_ready_strobe_n(data_ready_strobe_n), .dout(dout));
  sync_frame_host #(.CH(CH)) sync_frame_host_inst (
    .clk(clk), .sample_ready(sample_ready), .data_ready_strobe_n(data_ready_strobe_n),
    .dout(dout), .dclk(dclk), .words(words), .got(got));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ------
  // helpers
  // ------
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [15:0] d);
    logic fb;
    for (int i = 15; i >= 0; i--) begin
      fb = d[i] ^ c[7];
      c = {c[6:0], 1'b0} ^ {5'h00, fb, fb, fb};
    end
    return c;
  endfunction : crc_step
  function automatic logic [15:0] dat(input int g);
    return 16'(16'h5A00 + fc * 16'h0131 + g * 16'h0F0F);
  endfunction : dat
  function automatic logic [7:0] hdr(input int g);
    return 8'(8'hA0 + fc + g);
  endfunction : hdr
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic settle();
    repeat (6) @(posedge clk);
    foreach (acc[g]) acc[g] = 8'hFF;
  endtask : settle
  task automatic ext_sync();
    ext_sync_n <= 1'b0;
    @(posedge clk);
    ext_sync_n <= 1'b1;
    settle();
  endtask : ext_sync
  task automatic spi_sync();
    int w;
    w = 0;
    spi_sync_cmd <= 1'b1;
    @(posedge clk);
    spi_sync_cmd <= 1'b0;
    while (sync_out_n !== 1'b0 && w < 8) begin
      @(negedge clk);
      w++;
    end
    check("spi sync", sync_out_n, 1'b0);
    settle();
  endtask : spi_sync
  task automatic frame(input bit is_crc);
    int n0, w;
    while (sample_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    for (int g = 0; g < CH; g++) begin
      sample_data[g*16 +: 16] <= dat(g);
      status_hdr[g*8 +: 8] <= hdr(g);
    end
    sample_valid <= 1'b1;
    n0 = got;
    w = 0;
    @(posedge clk);
    sample_valid <= 1'b0;
    while (got == n0 && w < 2000) begin
      @(posedge clk);
      w++;
    end
    check("frame seen", got != n0, 1'b1);
    for (int g = 0; g < CH; g++) begin
      acc[g] = crc_step(acc[g], dat(g));
      check("word", {8'h00, words[g*24 +: 24]}, {8'h00, is_crc ? acc[g] : hdr(g), dat(g)});
      if (is_crc) acc[g] = 8'hFF;
    end
    fc++;
  endtask : frame
  // ------
  // scenarios
  // ------
  task automatic t_spi_refused();
    int lows;
    lows = 0;
    spi_mode <= 1'b0;
    spi_sync_cmd <= 1'b1;
    @(posedge clk);
    spi_sync_cmd <= 1'b0;
    repeat (6) begin
      @(negedge clk);
      if (sync_out_n !== 1'b1) lows++;
    end
    check("refused sync", lows, 0);
  endtask : t_spi_refused
  task automatic t_start();
    int w;
    w = 0;
    @(posedge clk);
    start_n <= 1'b0;
    while (sync_out_n !== 1'b0 && w < 12) begin
      @(negedge clk);
      w++;
    end
    check("start sync", sync_out_n, 1'b0);
    repeat (10) @(posedge clk);
    start_n <= 1'b1;
    settle();
  endtask : t_start
  task automatic t_crc_four();
    spi_mode <= 1'b1;
    crc_select <= 2'h1;
    spi_sync();
    repeat (2) frame(0);
    spi_sync(); // a resync in mid-group restarts the count
    repeat (3) frame(0);
    frame(1);
    repeat (3) frame(0);
    frame(1);
  endtask : t_crc_four
  task automatic t_crc_sixteen();
    spi_mode <= 1'b1;
    for (int s = 2; s < 4; s++) begin
      crc_select <= 2'(s);
      ext_sync();
      repeat (15) frame(0);
      frame(1);
    end
  endtask : t_crc_sixteen
  task automatic t_crc_off();
    for (int k = 0; k < 2; k++) begin
      spi_mode <= 1'(k);
      crc_select <= k ? 2'h0 : 2'h1;
      ext_sync();
      repeat (4) frame(0);
    end
  endtask : t_crc_off

  initial begin
    rst_n = 1'b0;
    start_n = 1'b1;
    ext_sync_n = 1'b1;
    spi_mode = 1'b0;
    spi_sync_cmd = 1'b0;
    crc_select = 2'h0;
    sample_valid = 1'b0;
    sample_data = '0;
    status_hdr = '0;
    foreach (acc[g]) acc[g] = 8'hFF;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_spi_refused();
    t_start();
    t_crc_four();
    t_crc_sixteen();
    t_crc_off();
    tally_and_finish();
  end
endmodule : test_sync_and_crc_header_framer

bind sync_crc_framer sync_crc_framer_assertions #(.CH(CH)) sync_crc_framer_assertions_inst (
  .clk(clk), .rst_n(rst_n), .start_n(start_n), .sync_out_n(sync_out_n),
  .spi_mode(spi_mode), .spi_sync_cmd(spi_sync_cmd), .sample_valid(sample_valid),
  .sample_ready(sample_ready), .data_ready_strobe_n(data_ready_strobe_n), .dout(dout));
